// File: hdl/radio_cell_framer_line_coder.sv
// bit-serial cell framer and line coder between a cell PHY and a radio modem
`timescale 1ns/1ps
module radio_cell_framer_line_coder (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // cells from the phy
  input wire framer_pkg::cell_byte_t txCell,
  input wire logic txValid,
  output logic txReady,
  // line toward the modulator
  output logic txLine,
  output logic txBitStrobe,
  // sliced signal from the demodulator
  input wire logic rxSlice,
  // cells to the phy
  output framer_pkg::cell_byte_t rxCell,
  output logic rxValid
);
  import framer_pkg::*;

  typedef struct packed {
    nco_t txAcc;
    tx_state_t txState;
    logic [7:0] txSh;
    logic [2:0] txBit;
    logic [2:0] txOnes;
    logic [5:0] txCnt;
    logic [7:0] txBuf;
    logic txBufFull;
    logic txReady;
    logic rawBit;
    logic rawValid;
    logic [2:0] rxSync;
    logic rxLvl;
    nco_t rxAcc;
    logic rxRaw;
    logic rxRawValid;
    logic [7:0] rxHunt;
    logic [2:0] rxOnes;
    logic rxInCell;
    logic [7:0] rxDat;
    logic [2:0] rxBit;
    logic [5:0] rxCnt;
    cell_byte_t rxCell;
    logic rxValid;
  } framer_state_t;

  framer_state_t st_r;
  framer_state_t st_nxt;
  logic decBit;
  logic decValid;

  // transmit coding, then receive decoding
  line_coder #(
    .ENCODE(1'b1)
  ) txCoder (
    .ref_clk(ref_clk),
    .rst(rst),
    .inBit(st_r.rawBit),
    .inValid(st_r.rawValid),
    .outBit(txLine),
    .outValid(txBitStrobe)
  );

  line_coder #(
    .ENCODE(1'b0)
  ) rxCoder (
    .ref_clk(ref_clk),
    .rst(rst),
    .inBit(st_r.rxRaw),
    .inValid(st_r.rxRawValid),
    .outBit(decBit),
    .outValid(decValid)
  );

  always_comb begin
    logic txWrap;
    logic rxWrap;
    logic rxEdge;
    logic stuffed;
    logic [7:0] hunt;
    txWrap = 1'b0;
    rxWrap = 1'b0;
    rxEdge = 1'b0;
    stuffed = 1'b0;
    hunt = '0;
    st_nxt = st_r;

    // transmit: byte hand-off from the phy
    if (txValid && st_r.txReady) begin
      st_nxt.txBuf = txCell.data;
      st_nxt.txBufFull = 1'b1;
    end

    // transmit: one bit per accumulator wrap
    {txWrap, st_nxt.txAcc} = ncoStep(st_r.txAcc);
    st_nxt.rawValid = txWrap;
    if (txWrap) begin
      unique case (st_r.txState)
        TX_DELIM: begin
          st_nxt.rawBit = st_r.txSh[7];
          st_nxt.txSh = {st_r.txSh[6:0], 1'b0};
          st_nxt.txBit = st_r.txBit + 3'h1;
          if (st_r.txBit == BIT_LAST) begin
            st_nxt.txSh = DELIM_BYTE;
            if (st_r.txBufFull) begin
              st_nxt.txSh = st_r.txBuf;
              st_nxt.txBufFull = 1'b0;
              st_nxt.txState = TX_DATA;
              st_nxt.txOnes = '0;
              st_nxt.txCnt = '0;
            end
          end
        end
        TX_DATA: begin
          if (st_r.txOnes == STUFF_RUN) begin
            st_nxt.rawBit = 1'b0;
            st_nxt.txOnes = '0;
          end else begin
            st_nxt.rawBit = st_r.txSh[7];
            st_nxt.txSh = {st_r.txSh[6:0], 1'b0};
            st_nxt.txOnes = st_r.txSh[7] ? st_r.txOnes + 3'h1 : 3'h0;
            st_nxt.txBit = st_r.txBit + 3'h1;
            if (st_r.txBit == BIT_LAST) begin
              if (st_r.txCnt == CELL_BYTES - 6'h1 || !st_r.txBufFull) begin
                // cell done, or phy ran dry: close with a delimiter
                st_nxt.txState = TX_DELIM;
                st_nxt.txSh = DELIM_BYTE;
              end else begin
                st_nxt.txSh = st_r.txBuf;
                st_nxt.txBufFull = 1'b0;
                st_nxt.txCnt = st_r.txCnt + 6'h1;
              end
            end
          end
        end
      endcase
    end
    st_nxt.txReady = !st_nxt.txBufFull;

    // receive: synchroniser and level filter
    st_nxt.rxSync = {st_r.rxSync[1:0], rxSlice};
    if (st_r.rxSync[1] == st_r.rxSync[2]) begin
      st_nxt.rxLvl = st_r.rxSync[2];
      rxEdge = st_r.rxSync[2] != st_r.rxLvl;
    end

    // receive: edges pull the sample point to mid-bit
    {rxWrap, st_nxt.rxAcc} = ncoStep(st_r.rxAcc);
    if (rxEdge) begin
      st_nxt.rxAcc = NCO_HALF;
    end
    st_nxt.rxRawValid = rxWrap && !rxEdge;
    st_nxt.rxRaw = st_r.rxLvl;

    // receive: delimiter hunt, destuffing and byte assembly
    st_nxt.rxValid = 1'b0;
    if (decValid) begin
      hunt = {st_r.rxHunt[6:0], decBit};
      st_nxt.rxHunt = hunt;
      if (hunt == DELIM_BYTE) begin
        st_nxt.rxInCell = 1'b1;
        st_nxt.rxCnt = '0;
        st_nxt.rxBit = '0;
        st_nxt.rxOnes = '0;
      end else begin
        stuffed = !decBit && st_r.rxOnes == STUFF_RUN;
        if (decBit) begin
          st_nxt.rxOnes = (st_r.rxOnes == ONES_MAX) ? ONES_MAX : st_r.rxOnes + 3'h1;
        end else begin
          st_nxt.rxOnes = '0;
        end
        if (st_r.rxInCell && !stuffed) begin
          st_nxt.rxDat = {st_r.rxDat[6:0], decBit};
          st_nxt.rxBit = st_r.rxBit + 3'h1;
          if (st_r.rxBit == BIT_LAST) begin
            st_nxt.rxCell.data = {st_r.rxDat[6:0], decBit};
            st_nxt.rxCell.soc = st_r.rxCnt == 6'h0;
            st_nxt.rxValid = 1'b1;
            st_nxt.rxCnt = st_r.rxCnt + 6'h1;
            if (st_r.rxCnt == CELL_BYTES - 6'h1) begin
              st_nxt.rxInCell = 1'b0;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.txSh <= DELIM_BYTE;
      st_r.txReady <= 1'b1;
      st_r.txState <= TX_DELIM;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign txReady = st_r.txReady;
  assign rxCell = st_r.rxCell;
  assign rxValid = st_r.rxValid;

endmodule

// File: inc/framer_pkg.sv
// constants, types and helpers shared by the cell framer and its line coder
package framer_pkg;

  // bit clock generation
  localparam longint CLK_HZ = 200000000;
  localparam longint BIT_RATE_HZ = 8448000;
  localparam int NCO_W = 24;
  localparam logic [NCO_W-1:0] NCO_INC = NCO_W'((BIT_RATE_HZ << NCO_W) / CLK_HZ);
  localparam logic [NCO_W-1:0] NCO_HALF = 24'h800000;

  // framing
  localparam logic [7:0] DELIM_BYTE = 8'h7E;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] ONES_MAX = 3'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [5:0] CELL_BYTES = 6'h35;

  // self-synchronising scrambler 1 + x^-6 + x^-7
  localparam int SCR_LEN = 7;
  localparam int SCR_TAP_A = 5;
  localparam int SCR_TAP_B = 6;

  typedef logic [NCO_W-1:0] nco_t;

  typedef struct packed {
    logic [7:0] data;
    logic soc;
  } cell_byte_t;

  typedef enum logic {
    TX_DELIM = 1'b0,
    TX_DATA = 1'b1
  } tx_state_t;

  // one accumulator step; the top bit is the wrap that marks a bit period
  function automatic logic [NCO_W:0] ncoStep(input nco_t acc);
    return {1'b0, acc} + {1'b0, NCO_INC};
  endfunction

endpackage

// File: hdl/line_coder.sv
// differential coder with self-synchronising scrambler, either direction
`timescale 1ns/1ps
module line_coder #(
  parameter bit ENCODE = 1'b1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // bit in
  input wire logic inBit,
  input wire logic inValid,
  // bit out
  output logic outBit,
  output logic outValid
);
  import framer_pkg::*;

  typedef struct packed {
    logic [SCR_LEN-1:0] sr;
    logic prev;
    logic outBit;
    logic outValid;
  } coder_state_t;

  coder_state_t st_r;
  coder_state_t st_nxt;

  always_comb begin
    logic d;
    d = 1'b0;
    st_nxt = st_r;
    st_nxt.outValid = inValid;
    if (inValid) begin
      if (ENCODE) begin
        d = inBit ^ st_r.prev;
        st_nxt.prev = d;
        st_nxt.outBit = d ^ st_r.sr[SCR_TAP_A] ^ st_r.sr[SCR_TAP_B];
        st_nxt.sr = {st_r.sr[SCR_LEN-2:0], st_nxt.outBit};
      end else begin
        d = inBit ^ st_r.sr[SCR_TAP_A] ^ st_r.sr[SCR_TAP_B];
        st_nxt.sr = {st_r.sr[SCR_LEN-2:0], inBit};
        st_nxt.outBit = d ^ st_r.prev;
        st_nxt.prev = d;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign outBit = st_r.outBit;
  assign outValid = st_r.outValid;

endmodule

// File: tb/framer_sva.sv
// port assertions for the cell framer
`timescale 1ns/1ps
module framer_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // watched ports
  input wire logic txValid,
  input wire logic txReady,
  input wire logic txLine,
  input wire logic txBitStrobe,
  input wire framer_pkg::cell_byte_t rxCell,
  input wire logic rxValid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_gap; txBitStrobe |-> ##[23:24] txBitStrobe; endproperty
  a_gap: assert property (p_gap) else $error("bit gap");
  property p_pulse; txBitStrobe |=> !txBitStrobe [*8]; endproperty
  a_pulse: assert property (p_pulse) else $error("bit pulse");
  property p_hold; !txBitStrobe |-> $stable(txLine); endproperty
  a_hold: assert property (p_hold) else $error("line moved");
  property p_take; txValid && txReady |=> !txReady; endproperty
  a_take: assert property (p_take) else $error("ready stuck");
  property p_back; $fell(txReady) |-> ##[1:600] txReady; endproperty
  a_back: assert property (p_back) else $error("ready late");
  property p_idle; !txValid && txReady |=> txReady; endproperty
  a_idle: assert property (p_idle) else $error("ready fell");
  property p_rx; rxValid |=> !rxValid [*8]; endproperty
  a_rx: assert property (p_rx) else $error("rx pulse");
  property p_rxHold; !rxValid |-> $stable(rxCell); endproperty
  a_rxHold: assert property (p_rxHold) else $error("rx moved");
endmodule

bind radio_cell_framer_line_coder framer_sva chk_u (
  .ref_clk(ref_clk), .rst(rst), .txValid(txValid), .txReady(txReady),
  .txLine(txLine), .txBitStrobe(txBitStrobe), .rxCell(rxCell), .rxValid(rxValid)
);

// File: tb/peer_model.sv
// cell source on the phy side and looped-back radio peer
`timescale 1ns/1ps
module peer_model (
  // clock
  input wire logic ref_clk,
  // cell source
  output framer_pkg::cell_byte_t txCell,
  output logic txValid,
  input wire logic txReady,
  // line loop
  input wire logic txLine,
  output logic rxSlice
);
  import framer_pkg::*;
  logic [7:0] byteQ[$];
  logic taken = 1'b0;
  initial begin
    txCell = '0;
    txValid = 1'b0;
  end
  always @(posedge ref_clk) taken <= txValid && txReady;
  // byte held until taken, then next offered; stale data inverted
  always @(negedge ref_clk) begin
    if (taken) void'(byteQ.pop_front());
    txValid <= byteQ.size() != 0;
    txCell <= byteQ.size() != 0 ? {byteQ[0], 1'b0} : {~txCell.data, 1'b0};
  end
  // far end loops the line straight back, 2 ns late
  assign #2 rxSlice = txLine;
endmodule

// File: tb/radio_cell_framer_line_coder_test.sv
// self-checking bench for the cell framer
`timescale 1ns/1ps
module radio_cell_framer_line_coder_test;
  import framer_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  cell_byte_t txCell, rxCell;
  logic txValid, txReady, txLine, txBitStrobe, rxSlice, rxValid;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int stbCnt = 0;
  int dlmHits = 0;
  logic [SCR_LEN-1:0] lineSr = '0;
  logic lineD = 1'b0;
  logic [7:0] rawHunt = '0;
  cell_byte_t rxQ[$];
  always #2.5 ref_clk = ~ref_clk;
  radio_cell_framer_line_coder dut_u (
    .ref_clk(ref_clk), .rst(rst), .txCell(txCell), .txValid(txValid), .txReady(txReady),
    .txLine(txLine), .txBitStrobe(txBitStrobe), .rxSlice(rxSlice), .rxCell(rxCell),
    .rxValid(rxValid)
  );
  peer_model peer_u (
    .ref_clk(ref_clk), .txCell(txCell), .txValid(txValid), .txReady(txReady),
    .txLine(txLine), .rxSlice(rxSlice)
  );
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    // independent line decoder: descramble, then differential decode, then hunt delimiters
    if (txBitStrobe === 1'b1) begin
      stbCnt++;
      rawHunt = {rawHunt[6:0], txLine ^ lineSr[SCR_TAP_A] ^ lineSr[SCR_TAP_B] ^ lineD};
      lineD = txLine ^ lineSr[SCR_TAP_A] ^ lineSr[SCR_TAP_B];
      lineSr = {lineSr[SCR_LEN-2:0], txLine};
      if (rawHunt == DELIM_BYTE) dlmHits++;
    end
    if (rxValid === 1'b1) rxQ.push_back(rxCell);
    if (cycles == 70000) begin
      error_cnt++;
      end_of_test();
    end
  end
  function automatic logic [7:0] pat(input int i);
    return i % 4 == 0 ? 8'hFF : i % 4 == 1 ? 8'h7E : 8'(i * 37);
  endfunction
  task automatic idle_rate();
    int s0;
    int h0;
    longint lo;
    s0 = stbCnt;
    h0 = dlmHits;
    lo = (longint'(2400) * NCO_INC) >> NCO_W;
    repeat (2400) @(negedge ref_clk);
    chk("strobes", 9'h001, 9'(stbCnt - s0 >= lo && stbCnt - s0 <= lo + 1));
    chk("line delims", 9'((stbCnt - s0) / 8), 9'(dlmHits - h0));
    chk("idle bytes", 9'h000, 9'(rxQ.size()));
    chk("ready", 9'h001, 9'(txReady));
    $display("test idle_rate done");
  endtask
  task automatic send_cells(input int n);
    int got;
    rxQ.delete();
    for (int i = 0; i < n * 53; i++) peer_u.byteQ.push_back(pat(i));
    for (int k = 0; k < 40000 && rxQ.size() < n * 53; k++) @(negedge ref_clk);
    repeat (800) @(negedge ref_clk);
    got = rxQ.size();
    chk("byte count", 9'(n * 53), 9'(got));
    for (int i = 0; i < n * 53 && i < got; i++) chk("rx byte", {pat(i), i % 53 == 0}, rxQ[i]);
  endtask
  task automatic one_cell();
    send_cells(1);
    $display("test one_cell done");
  endtask
  task automatic two_cells();
    send_cells(2);
    $display("test two_cells done");
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    idle_rate();
    one_cell();
    two_cells();
    end_of_test();
  end
endmodule
